// ---- rtl/pmw_pkg.sv ----
/*
  constants and types for the power mode, wake-up and watchdog block.
  assumes one 200 MHz clock; all other clocks arrive as enables/pins.
*/
package pmw_pkg;
  localparam int          CLK_PERIOD_NS     = 5;
  localparam int          STARTUP_PERIODS   = 1024;
  localparam logic [10:0] STARTUP_LAST      = 11'h3ff;
  localparam int          INSTR_DIV         = 4;
  localparam logic [1:0]  INSTR_DIV_LAST    = 2'h3;
  // watchdog clock source select codes
  localparam logic [1:0]  WDSRC_INTERNAL    = 2'h0;
  localparam logic [1:0]  WDSRC_XTAL        = 2'h1;
  localparam logic [1:0]  WDSRC_INSTR       = 2'h2;
  // register addresses, bit positions inside the mode byte and its reset value
  localparam int          MODE_HALT_DEPTH   = 0;
  localparam int          MODE_FAST_SEL     = 1;
  localparam int          MODE_FREQ_UP      = 2;
  localparam logic [3:0]  ADDR_MODE         = 4'h0;
  localparam logic [3:0]  ADDR_STATUS       = 4'h1;
  localparam logic [7:0]  MODE_RESET        = 8'h00;

  typedef enum logic [4:0] {
    ST_GREEN  = 5'b00001,
    ST_NORMAL = 5'b00010,
    ST_SLEEP  = 5'b00100,
    ST_IDLE   = 5'b01000,
    ST_WAKE   = 5'b10000
  } op_mode_t;
endpackage : pmw_pkg

// ---- rtl/pin_sync3.sv ----
/*
  three-flop synchroniser with agreement filter for a bus of pins.
  assumes inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts only once the second and third stage agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pin_out[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          pin_out[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync3
`default_nettype wire

// ---- rtl/power_mode_wakeup_watchdog.sv ----
/*
  operating mode control, power-down/wake-up sequencing and watchdog.
  assumes the core gives one-cycle instruction pulses and obeys stall;
  the 32768 Hz clock and watchdog oscillator arrive as pins and are
  sampled here, and the fast clock is represented by a tick input.
*/
`timescale 1ns/100ps
`default_nettype none
module power_mode_wakeup_watchdog
  import pmw_pkg::*;
#(
  parameter int WD_BITS    = 15,
  parameter int PA_WIDTH   = 8,
  parameter int IRQ_WIDTH  = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // core instruction events
  input  wire logic                 halt_exec,
  input  wire logic                 wd_clear_single,
  input  wire logic                 wd_clear_first_half,
  input  wire logic                 wd_clear_second_half,
  input  wire logic                 stack_full,
  // interrupts: request flags, enables, clock-derived sources
  input  wire logic [IRQ_WIDTH-1:0] irq_req,
  input  wire logic [IRQ_WIDTH-1:0] irq_en,
  input  wire logic [IRQ_WIDTH-1:0] irq_xtal_src,
  // pins
  input  wire logic                 external_reset_pin_n,
  input  wire logic [PA_WIDTH-1:0]  port_a_pin,
  input  wire logic                 xtal_32k_pin,
  input  wire logic                 wd_osc_pin,
  input  wire logic                 fast_clk_tick,
  // configuration options
  input  wire logic [PA_WIDTH-1:0]  cfg_pa_wake_en,
  input  wire logic                 cfg_wd_enable,
  input  wire logic [1:0]           cfg_wd_src,
  input  wire logic                 cfg_wd_paired,
  // outputs to core and clock tree
  output logic                      core_stall,
  output logic                      sys_clk_en,
  output logic                      sys_clk_is_fast,
  output logic                      xtal_osc_en,
  output logic                      fast_osc_en,
  output logic                      irq_take,
  output logic                      resume_next,
  output logic [IRQ_WIDTH-1:0]      irq_gate,
  output logic                      full_reset,
  output logic                      pc_sp_reset,
  output logic                      power_down_flag,
  output logic                      watchdog_timeout_flag,
  output logic [1:0]                op_mode_code
);
  op_mode_t mode_r;
  logic [7:0]            mode_reg_r;
  logic                  halt_depth_select;
  logic                  fast_clock_select;
  logic                  freq_up_enable;
  logic [10:0]           wakeup_startup_delay;
  logic                  wake_irq_r;
  logic [IRQ_WIDTH-1:0]  irq_masked_r;
  logic [WD_BITS-1:0]    watchdog_counter;
  logic [1:0]            wd_prescale_r;
  logic                  half_seen_r;
  logic                  half_which_r;
  logic                  xtal_prev_r;
  logic                  wdosc_prev_r;
  logic [2:0]            pin_sync;
  logic [PA_WIDTH-1:0]   pa_sync;
  logic [PA_WIDTH-1:0]   pa_prev_r;
  logic                  xtal_tick;
  logic                  wdosc_tick;
  logic                  instr_tick;
  logic [1:0]            instr_div_r;
  logic                  halted;
  logic                  pa_wake;
  logic                  irq_wake;
  logic                  wake;
  logic                  wd_tick;
  logic                  wd_run;
  logic                  wd_soft_clear;
  logic                  wd_ovf;
  logic                  ext_reset;
  logic                  halt_ok;

  assign halt_depth_select = mode_reg_r[MODE_HALT_DEPTH];
  assign fast_clock_select = mode_reg_r[MODE_FAST_SEL];
  assign freq_up_enable    = mode_reg_r[MODE_FREQ_UP];

  pin_sync3 #(
    .W (3)
  ) u_sync_clk (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  ({!external_reset_pin_n, wd_osc_pin, xtal_32k_pin}),
    .pin_out (pin_sync)
  );

  pin_sync3 #(
    .W (PA_WIDTH)
  ) u_sync_pa (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (port_a_pin),
    .pin_out (pa_sync)
  );

  // synced inverted so that cleared flops mean an idle pin, not a reset
  assign ext_reset = pin_sync[2];
  assign xtal_tick = pin_sync[0] && !xtal_prev_r;
  assign wdosc_tick = pin_sync[1] && !wdosc_prev_r;
  assign halted = (mode_r == ST_SLEEP) || (mode_r == ST_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xtal_prev_r  <= 1'b0;
      wdosc_prev_r <= 1'b0;
      pa_prev_r    <= '0;
    end else begin
      xtal_prev_r  <= pin_sync[0];
      wdosc_prev_r <= pin_sync[1];
      pa_prev_r    <= pa_sync;
    end
  end

  // system clock ticks: fast in normal, crystal in green
  // instruction clock is a quarter of it and stops when halted
  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset) begin
      instr_div_r <= 2'h0;
    end else if (!halted && mode_r != ST_WAKE &&
                 ((mode_r == ST_NORMAL) ? fast_clk_tick : xtal_tick)) begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end
  assign instr_tick = !halted && mode_r != ST_WAKE &&
                      instr_div_r == INSTR_DIV_LAST &&
                      ((mode_r == ST_NORMAL) ? fast_clk_tick : xtal_tick);

  // a port A bit wakes only when enabled by option and it changes
  assign pa_wake  = |((pa_sync ^ pa_prev_r) & cfg_pa_wake_en);
  // flags already set at halt are masked out of the wake logic
  // crystal-clocked sources are blind in idle
  always_comb begin
    irq_gate = irq_req & ~irq_masked_r;
    if (mode_r == ST_IDLE) begin
      irq_gate = irq_gate & ~irq_xtal_src;
    end
  end
  assign irq_wake = |irq_gate;
  assign wake = halted && (pa_wake || irq_wake);

  // mode register, halt depth auto-clear on leaving idle
  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset || full_reset) begin
      mode_reg_r <= MODE_RESET;
    end else if (mode_r == ST_IDLE && (wake || pc_sp_reset)) begin
      mode_reg_r[MODE_HALT_DEPTH] <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_MODE) begin
      mode_reg_r <= {5'h00, reg_wdata[2:0]};
    end
  end

  // halt only legal once fast select and freq-up are both clear
  assign halt_ok = halt_exec && !fast_clock_select && !freq_up_enable;

  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset || full_reset) begin
      mode_r <= ST_GREEN;
    end else begin
      unique case (mode_r)
        ST_GREEN: begin
          if (halt_ok) begin
            mode_r <= halt_depth_select ? ST_IDLE : ST_SLEEP;
          end else if (fast_clock_select && freq_up_enable) begin
            mode_r <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (!fast_clock_select) begin
            mode_r <= ST_GREEN;
          end
        end
        ST_SLEEP, ST_IDLE: begin
          if (wake || pc_sp_reset) begin
            mode_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (xtal_tick && wakeup_startup_delay == STARTUP_LAST) begin
            mode_r <= ST_GREEN;
          end
        end
      endcase
    end
  end

  // start-up delay counted on the crystal, which is green's clock
  always_ff @(posedge clk) begin
    if (!rst_n || mode_r != ST_WAKE) begin
      wakeup_startup_delay <= 11'h000;
    end else if (xtal_tick) begin
      wakeup_startup_delay <= wakeup_startup_delay + 11'h001;
    end
  end

  // remember why we woke and what was pending at halt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_irq_r   <= 1'b0;
      irq_masked_r <= '0;
    end else begin
      if (halt_ok && mode_r == ST_GREEN) begin
        irq_masked_r <= irq_req;
      end else if (!halted) begin
        irq_masked_r <= '0;
      end
      if (wake || (halted && pc_sp_reset)) begin
        wake_irq_r <= wake && irq_wake && !pa_wake;
      end
    end
  end

  // at the end of the delay, service or fall through
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_take    <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      irq_take    <= 1'b0;
      resume_next <= 1'b0;
      if (mode_r == ST_WAKE && xtal_tick &&
          wakeup_startup_delay == STARTUP_LAST) begin
        if (wake_irq_r && |(irq_req & irq_en) && !stack_full) begin
          irq_take <= 1'b1;
        end else begin
          resume_next <= 1'b1;
        end
      end
    end
  end

  // watchdog clock source and when it keeps running
  always_comb begin
    unique case (cfg_wd_src)
      WDSRC_XTAL: begin
        wd_tick = xtal_tick;
        wd_run  = mode_r != ST_IDLE;
      end
      WDSRC_INSTR: begin
        wd_tick = instr_tick;
        wd_run  = !halted;
      end
      default: begin
        wd_tick = wdosc_tick;
        wd_run  = 1'b1;
      end
    endcase
  end

  // single or paired software clear; disabled watchdog ignores all
  always_comb begin
    wd_soft_clear = 1'b0;
    if (cfg_wd_enable) begin
      if (!cfg_wd_paired) begin
        wd_soft_clear = wd_clear_single;
      end else if (wd_clear_first_half) begin
        wd_soft_clear = half_seen_r && half_which_r;
      end else if (wd_clear_second_half) begin
        wd_soft_clear = half_seen_r && !half_which_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset || !cfg_wd_enable || !cfg_wd_paired) begin
      half_seen_r  <= 1'b0;
      half_which_r <= 1'b0;
    end else if (wd_soft_clear) begin
      half_seen_r  <= 1'b0;
    end else if (wd_clear_first_half || wd_clear_second_half) begin
      half_seen_r  <= 1'b1;
      half_which_r <= wd_clear_second_half;
    end
  end

  assign wd_ovf = cfg_wd_enable && wd_run && wd_tick &&
                  wd_prescale_r == INSTR_DIV_LAST && &watchdog_counter;

  // cleared by the pin, the clear instructions or halt
  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset || wd_soft_clear || !cfg_wd_enable ||
        (halt_ok && mode_r == ST_GREEN)) begin
      watchdog_counter <= '0;
      wd_prescale_r    <= 2'h0;
    end else if (wd_run && wd_tick) begin
      wd_prescale_r <= wd_prescale_r + 2'h1;
      if (wd_prescale_r == INSTR_DIV_LAST) begin
        watchdog_counter <= watchdog_counter + 1'b1;
      end
    end
  end

  // overflow effect depends on whether the device is halted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      full_reset  <= 1'b0;
      pc_sp_reset <= 1'b0;
    end else begin
      full_reset  <= wd_ovf && !halted;
      pc_sp_reset <= wd_ovf && halted;
    end
  end

  // status flags; pin reset clears both, halt sets power-down
  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (wd_ovf) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (halt_ok && mode_r == ST_GREEN) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  // kept apart so an overflow in the halt cycle cannot lose the set
  always_ff @(posedge clk) begin
    if (!rst_n || ext_reset) begin
      power_down_flag <= 1'b0;
    end else if (halt_ok && mode_r == ST_GREEN) begin
      power_down_flag <= 1'b1;
    end else if (wd_soft_clear) begin
      power_down_flag <= 1'b0;
    end
  end

  // clock tree controls; state is held simply by not clocking
  assign core_stall      = halted || mode_r == ST_WAKE;
  assign sys_clk_en      = !core_stall;
  assign sys_clk_is_fast = mode_r == ST_NORMAL;
  assign xtal_osc_en     = mode_r != ST_IDLE;
  assign fast_osc_en     = freq_up_enable && !halted;

  always_comb begin
    unique case (mode_r)
      ST_NORMAL: op_mode_code = 2'h3;
      ST_SLEEP:  op_mode_code = 2'h1;
      ST_IDLE:   op_mode_code = 2'h0;
      default:   op_mode_code = 2'h2;
    endcase
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == ADDR_MODE) begin
      reg_rdata <= mode_reg_r;
    end else if (reg_rd && reg_addr == ADDR_STATUS) begin
      reg_rdata <= {3'h0, op_mode_code, mode_r == ST_WAKE,
                    watchdog_timeout_flag, power_down_flag};
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : power_mode_wakeup_watchdog
`default_nettype wire

// ---- test/osc_model.sv ----
/*
  oscillator model for the far side of the power mode block.
  assumes the block gates the crystal and fast clock with its enables.
*/
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
  parameter real XT_HALF = 10.3
) (
  // clock
  input  wire logic clk,
  // enables from the block
  input  wire logic xtal_osc_en,
  input  wire logic fast_osc_en,
  // oscillator outputs
  output logic      xtal_32k_pin,
  output logic      wd_osc_pin,
  output logic      fast_clk_tick
);
  int fdiv = 0;

  initial begin
    xtal_32k_pin  = 1'b0;
    wd_osc_pin    = 1'b0;
    fast_clk_tick = 1'b0;
  end

  // crystal freezes in idle, so idle wake-ups must restart it
  always #(XT_HALF)
    if (xtal_osc_en) xtal_32k_pin = ~xtal_32k_pin;
  // watchdog oscillator runs free, even in power-down
  always #15.1 wd_osc_pin = ~wd_osc_pin;

  always @(posedge clk) begin
    fdiv          <= (fdiv + 1) % 3;
    fast_clk_tick <= fast_osc_en && fdiv == 0;
  end
endmodule : osc_model
`default_nettype wire

// ---- test/pmw_sva.sv ----
/*
  port assertions for the power mode, wake-up and watchdog block.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pmw_sva #(
  parameter int PA_WIDTH = 8
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // inputs watched
  input wire logic                halt_exec,
  input wire logic [PA_WIDTH-1:0] port_a_pin,
  input wire logic [PA_WIDTH-1:0] cfg_pa_wake_en,
  input wire logic                cfg_wd_enable,
  // outputs watched
  input wire logic                core_stall,
  input wire logic                sys_clk_en,
  input wire logic                sys_clk_is_fast,
  input wire logic                xtal_osc_en,
  input wire logic                fast_osc_en,
  input wire logic                irq_take,
  input wire logic                resume_next,
  input wire logic                full_reset,
  input wire logic                pc_sp_reset,
  input wire logic                power_down_flag,
  input wire logic [1:0]          op_mode_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_pdf_cause;
    $rose(power_down_flag) |-> $past(halt_exec);
  endproperty
  a_pdf_cause: assert property (p_pdf_cause)
    else $error("power-down flag set without halt");

  property p_halt_stops;
    op_mode_code inside {2'h0, 2'h1} |-> core_stall && !sys_clk_en;
  endproperty
  a_halt_stops: assert property (p_halt_stops)
    else $error("system clock runs while halted");

  property p_idle_osc;
    op_mode_code == 2'h0 |-> !xtal_osc_en && !fast_osc_en;
  endproperty
  a_idle_osc: assert property (p_idle_osc)
    else $error("oscillator on in idle");

  property p_normal_fast;
    op_mode_code == 2'h3 |-> sys_clk_is_fast && fast_osc_en && xtal_osc_en;
  endproperty
  a_normal_fast: assert property (p_normal_fast)
    else $error("normal mode not on fast clock");

  property p_green_slow;
    op_mode_code == 2'h2 && !core_stall |-> !sys_clk_is_fast && xtal_osc_en;
  endproperty
  a_green_slow: assert property (p_green_slow)
    else $error("green mode not on crystal");

  property p_full_rst;
    full_reset |-> $past(op_mode_code) >= 2'h2;
  endproperty
  a_full_rst: assert property (p_full_rst)
    else $error("full reset from a halted mode");

  property p_halted_rst;
    pc_sp_reset |-> $past(core_stall) && op_mode_code != 2'h3;
  endproperty
  a_halted_rst: assert property (p_halted_rst)
    else $error("partial reset while running");

  property p_wd_off;
    !cfg_wd_enable && !$past(cfg_wd_enable) |-> !full_reset && !pc_sp_reset;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("disabled watchdog caused a reset");

  property p_pa_wake;
    !op_mode_code[1] && |((port_a_pin ^ $past(port_a_pin)) & cfg_pa_wake_en)
      |-> ##[1:10] op_mode_code == 2'h2;
  endproperty
  a_pa_wake: assert property (p_pa_wake)
    else $error("port change did not wake");

  property p_one_outcome;
    irq_take || resume_next |-> !(irq_take && resume_next) && !core_stall
      ##1 !irq_take && !resume_next;
  endproperty
  a_one_outcome: assert property (p_one_outcome)
    else $error("bad resume pulse");
endmodule : pmw_sva

bind power_mode_wakeup_watchdog pmw_sva #(.PA_WIDTH(PA_WIDTH)) chk (
  .clk, .rst_n, .halt_exec, .port_a_pin, .cfg_pa_wake_en, .cfg_wd_enable,
  .core_stall, .sys_clk_en, .sys_clk_is_fast, .xtal_osc_en, .fast_osc_en,
  .irq_take, .resume_next, .full_reset, .pc_sp_reset, .power_down_flag,
  .op_mode_code
);
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  self-checking bench for the power mode, wake-up and watchdog block.
  assumes the oscillator model feeds the crystal and watchdog pins.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pmw_pkg::*;
;
  localparam real XT_HALF = 10.3;
  localparam int  LO = int'(STARTUP_PERIODS * 2.0 * XT_HALF / 5.0) - 40;
  logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       halt_exec = 1'b0, wd_clear_single = 1'b0, stack_full = 1'b0;
  logic       wd_clear_first_half = 1'b0, wd_clear_second_half = 1'b0;
  logic       external_reset_pin_n = 1'b1, cfg_wd_paired = 1'b0;
  logic       cfg_wd_enable = 1'b0;
  logic [1:0] cfg_wd_src = WDSRC_INTERNAL;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, irq_req = 8'h00, irq_en = 8'hff;
  logic [7:0] irq_xtal_src = 8'h03, port_a_pin = 8'h00;
  logic [7:0] cfg_pa_wake_en = 8'h5a, reg_rdata, irq_gate;
  logic       core_stall, sys_clk_en, sys_clk_is_fast, xtal_osc_en;
  logic       fast_osc_en, irq_take, resume_next, full_reset, pc_sp_reset;
  logic       power_down_flag, watchdog_timeout_flag;
  logic       xtal_32k_pin, wd_osc_pin, fast_clk_tick;
  logic [1:0] op_mode_code;
  int         fails = 0, n_tests = 0, nres = 0, mdl_mode = 0, res_at = 0;

  power_mode_wakeup_watchdog #(.WD_BITS(4)) uut (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .halt_exec, .wd_clear_single, .wd_clear_first_half,
    .wd_clear_second_half, .stack_full, .irq_req, .irq_en, .irq_xtal_src,
    .external_reset_pin_n, .port_a_pin, .xtal_32k_pin, .wd_osc_pin,
    .fast_clk_tick, .cfg_pa_wake_en, .cfg_wd_enable, .cfg_wd_src,
    .cfg_wd_paired, .core_stall, .sys_clk_en, .sys_clk_is_fast,
    .xtal_osc_en, .fast_osc_en, .irq_take, .resume_next, .irq_gate,
    .full_reset, .pc_sp_reset, .power_down_flag, .watchdog_timeout_flag,
    .op_mode_code
  );
  osc_model #(.XT_HALF(XT_HALF)) osc (
    .clk, .xtal_osc_en, .fast_osc_en, .xtal_32k_pin, .wd_osc_pin,
    .fast_clk_tick
  );

  always #2.5 clk = ~clk;

  function automatic logic [1:0] code_of(input int m);
    return (m[1] && m[2]) ? 2'h3 : 2'h2;
  endfunction : code_of

  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic halt_to(input int m);
    mdl_mode = m;
    wr(ADDR_MODE, 8'(m));
    @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    settle;
    chk(8'(op_mode_code), m[0] ? 8'h0 : 8'h1);
    chk(8'({core_stall, power_down_flag, watchdog_timeout_flag}),
        8'h6);
  endtask : halt_to

  // counts stalled cycles, then catches the resume pulse just after
  // pre: stalled cycles already spent in the delay before the call
  task automatic wake_wait(input logic [1:0] outc, input int pre);
    int cyc, n4;
    logic tk, rs;
    cyc = 0;
    n4 = 0;
    tk = 1'b0;
    rs = 1'b0;
    for (int i = 0; i < 9000 && n4 < 4; i++) begin
      @(posedge clk);
      #1;
      if (core_stall === 1'b1) cyc++;
      else n4++;
      tk |= irq_take;
      rs |= resume_next;
    end
    chk(8'(cyc + pre >= LO && cyc + pre < LO + 140), 8'h1);
    chk(8'({tk, rs}), 8'(outc));
    chk(8'(op_mode_code), 8'h2);
    mdl_mode = mdl_mode & 6;
  endtask : wake_wait

  // k: 0 no clears, 1 single, 2 first half only, 3 both halves
  task automatic wd_run(input int n, input int k, input logic en);
    nres = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      cfg_wd_enable <= en && i < n - 1;
      wd_clear_single <= k == 1 && i % 100 == 0;
      wd_clear_first_half <= k == 2 && i % 100 == 0 || k == 3 && i % 100 == 50;
      wd_clear_second_half <= k == 3 && i % 100 == 0;
      #1 if (full_reset || pc_sp_reset) begin
        if (nres == 0) res_at = n - i;
        nres++;
      end
    end
  endtask : wd_run

  initial begin
    int b;
    logic [7:0] d;
    b = $urandom(19883);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STATUS, d);
    chk(d, 8'h10);
    rd(4'h9, d);
    chk(d, 8'h00);
    for (int j = 0; j < 3; j++) begin
      mdl_mode = j == 1 ? 6 : 4;
      wr(ADDR_MODE, 8'(mdl_mode));
      settle;
      chk(8'(op_mode_code), 8'(code_of(mdl_mode)));
      rd(ADDR_MODE, d);
      chk(d, 8'(mdl_mode));
    end
    wr(ADDR_MODE, 8'h06);
    external_reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    external_reset_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ADDR_MODE, d);
    chk(d, 8'h00);
    for (int k = 0; k < 4; k++) begin
      cfg_wd_paired <= k > 1;
      wd_run(1000, k, 1'b1);
      chk(8'(nres > 0), 8'(k % 2 == 0));
      if (k == 0) chk(8'(watchdog_timeout_flag), 8'h1);
    end
    cfg_wd_src <= WDSRC_XTAL;
    wd_run(1000, 0, 1'b1);
    chk(8'(nres > 0), 8'h1);
    wd_run(1000, 1, 1'b0);
    chk(8'(nres), 8'h0);
    halt_to(0);
    port_a_pin <= port_a_pin ^ 8'h01;
    repeat (20) @(posedge clk);
    #1 chk(8'(op_mode_code), 8'h1);
    do b = $urandom_range(7); while (!cfg_pa_wake_en[b]);
    port_a_pin[b] <= ~port_a_pin[b];
    wake_wait(2'b01, 0);
    rd(ADDR_STATUS, d);
    chk(d, 8'h11);
    for (int i = 0; i < 3; i++) begin
      halt_to(1);
      // crystal-fed source cannot fire while the crystal is stopped
      irq_req <= 8'h01;
      repeat (30) @(posedge clk);
      #1 chk(8'(op_mode_code), 8'h0);
      chk(irq_gate, 8'h00);
      stack_full <= i == 1;
      irq_en <= i == 2 ? 8'h00 : 8'hff;
      irq_req <= 8'h11;
      wake_wait(i == 0 ? 2'b10 : 2'b01, 0);
      irq_req <= 8'h00;
      rd(ADDR_MODE, d);
      chk(d, 8'(mdl_mode));
    end
    irq_en <= 8'hff;
    irq_req <= 8'h20;
    halt_to(0);
    cfg_wd_src <= WDSRC_INSTR;
    wd_run(800, 0, 1'b1);
    chk(8'(nres), 8'h0);
    chk(8'(op_mode_code), 8'h1);
    chk(irq_gate, 8'h00);
    cfg_wd_src <= WDSRC_INTERNAL;
    // a halted overflow is a reset condition and so a wake-up; the run
    // is short enough that only one overflow lands
    wd_run(500, 0, 1'b1);
    chk(8'({nres > 0, op_mode_code}), 8'h6);
    port_a_pin <= port_a_pin ^ 8'h02;
    wake_wait(2'b01, res_at);
    irq_req <= 8'h00;
    tally_and_finish;
  end

  // runs take about 145 us; this margin only trips on a hang
  initial begin
    #400us;
    fails++;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
